// File: core/asc_consts.svh
// Purpose: Constants of the serial configuration register bank
// Assumes: Included by its bare name
// Notes: Offsets are 3-bit register addresses
`ifndef ASC_CONSTS_SVH
`define ASC_CONSTS_SVH
`define ASC_ADDR_W 3
`define ASC_DATA_W 16
`define ASC_FRAME_W 19
`define ASC_XFER_COUNT 5'h13
`define ASC_ADDR_CTRL 3'h0
`define ASC_ADDR_GAIN 3'h1
`define ASC_ADDR_OFFS 3'h2
`define ASC_ADDR_SPARE 3'h3
`define ASC_ADDR_INTL 3'h4
`define ASC_ADDR_PAT 3'h5
`define ASC_RST_CTRL 16'h0040
`define ASC_RST_GAIN 16'h0080
`define ASC_RST_OFFS 16'h0080
`define ASC_RST_INTL 16'h1410
`define ASC_RST_PAT 16'h0000
`define ASC_CTRL_STANDBY_BIT_BIT 0
`define ASC_CTRL_TH_BIT 3
`define ASC_CTRL_PTEST_BIT 7
`define ASC_TRIM8_MSB 7
`define ASC_LEVEL_MSB 4
`define ASC_LEVEL_LSB 0
`define ASC_SETTLE_MSB 6
`define ASC_SETTLE_LSB 5
`define ASC_DUTY_MSB 15
`define ASC_DUTY_LSB 13
`define ASC_PAT_MSB 11
`endif

// File: core/asc_pkg.sv
// Purpose: Types of the serial configuration register bank
// Assumes: Constants header in the include path
// Notes: One packed state struct per clock domain
`include "asc_consts.svh"
package asc_pkg;
  typedef enum logic [1:0] {
    ASC_WAIT_HIGH,
    ASC_ARMED,
    ASC_SHIFT,
    ASC_DONE
  } asc_phase_t;

  typedef struct packed {
    asc_phase_t phase;
    logic [4:0] count;
    logic [`ASC_FRAME_W-1:0] shift;
    logic [`ASC_FRAME_W-1:0] hold;
    logic toggle;
  } asc_link_state_t;

  typedef struct packed {
    logic [`ASC_DATA_W-1:0] ctrl;
    logic [`ASC_DATA_W-1:0] gain;
    logic [`ASC_DATA_W-1:0] offs;
    logic [`ASC_DATA_W-1:0] intl;
    logic [`ASC_DATA_W-1:0] pat;
    logic toggle_seen;
    logic write_strobe;
    logic [`ASC_ADDR_W-1:0] write_addr;
    logic port_active;
    logic [`ASC_PAT_MSB:0] out_bits;
    logic [`ASC_PAT_MSB:0] inv_bits;
  } asc_core_state_t;
endpackage : asc_pkg

// File: core/asc_sync.sv
// Purpose: Two-flop level synchroniser
// Assumes: Input is a slow level
// Notes: First stage feeds only the second
`timescale 1ns/1ps
`default_nettype none
module asc_sync #(
  parameter int WIDTH = 1
) (
  // Clock
  input wire logic clk_i,
  // Level
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [1:0][WIDTH-1:0] state;
  logic [1:0][WIDTH-1:0] next_state;

  always_comb begin
    next_state[0] = async_i;
    next_state[1] = state[0];
  end

  always_ff @(posedge clk_i) begin
    state <= next_state;
  end

  assign sync_o = state[1];
endmodule : asc_sync
`default_nettype wire

// File: core/asc_link_shift.sv
// Purpose: Serial write receiver on the serial clock
// Assumes: Load enable and data are synchronous to the serial clock
// Notes: Completed words are held stable and announced by a toggle
`timescale 1ns/1ps
`default_nettype none
`include "asc_consts.svh"
module asc_link_shift
  import asc_pkg::*;
(
  // Serial clock domain
  input wire logic link_clk_i,
  input wire logic link_reset_n_i,
  input wire logic port_on_i,
  // Serial pins
  input wire logic load_en_n_i,
  input wire logic serial_data_i,
  // Word toward the core
  output logic [`ASC_FRAME_W-1:0] word_o,
  output logic word_toggle_o
);
  import asc_pkg::*;
  asc_link_state_t st;
  asc_link_state_t next_st;

  always_comb begin
    next_st = st;
    case (st.phase)
      ASC_WAIT_HIGH: begin
        if (load_en_n_i) begin // RULE17
          next_st.phase = ASC_ARMED;
        end
      end
      ASC_ARMED: begin
        if (!load_en_n_i) begin // RULE17
          next_st.shift = {st.shift[`ASC_FRAME_W-2:0], serial_data_i};
          next_st.count = 5'h1;
          next_st.phase = ASC_SHIFT;
        end
      end
      ASC_SHIFT: begin
        if (load_en_n_i) begin
          next_st.phase = ASC_ARMED; // RULE19
        end else if (st.count == `ASC_XFER_COUNT) begin
          next_st.hold = st.shift; // RULE18
          next_st.toggle = ~st.toggle;
          next_st.phase = ASC_DONE;
        end else begin
          next_st.shift = {st.shift[`ASC_FRAME_W-2:0], serial_data_i}; // RULE2
          next_st.count = st.count + 5'h1;
        end
      end
      default: begin
        if (load_en_n_i) begin // RULE18
          next_st.phase = ASC_ARMED;
        end
      end
    endcase
    if (!port_on_i) begin
      next_st.phase = ASC_WAIT_HIGH; // RULE1
      next_st.count = 5'h0;
    end
  end

  always_ff @(posedge link_clk_i) begin
    if (!link_reset_n_i) begin
      st <= '{phase: ASC_WAIT_HIGH, count: 5'h0, shift: '0, hold: '0, toggle: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign word_o = st.hold;
  assign word_toggle_o = st.toggle;
endmodule : asc_link_shift
`default_nettype wire

// File: core/asc_regs.sv
// Purpose: Serial configuration register bank of a converter
// Assumes: Serial clock runs while writes are made; port select held low 3+ core cycles
// Notes: Write-only bank; fields are static outputs toward trim and mode logic
// Functional notes
// RULE1 - Writes are taken only while port select is high; low makes port inactive.
// RULE2 - Every write carries a 3-bit address then a 16-bit data word.
// RULE3 - Address decode: 0 control, 1 gain, 2 offset, 4 trims, 5 pattern; 3 ignored.
// RULE4 - Standby bit one means full standby; standby leaves register contents alone.
// RULE5 - Controller should apply a timing reset after leaving standby.
// RULE6 - Track/hold transparent bit turns transparent mode on at one, off at zero.
// RULE7 - Gain trim is data bits 7 to 0 of address 1; upper bits ignored.
// RULE8 - Gain trim resets to 0x80, zero gain adjustment.
// RULE9 - Offset trim is data bits 7 to 0 of address 2.
// RULE10 - Offset trim resets to 0x80, zero offset.
// RULE11 - Trims word: duty ratio top three bits, settling delay middle, level low five.
// RULE12 - Level trim is five bits, reset value 10000.
// RULE13 - Settling delay trim is two bits, reset value 00.
// RULE14 - Duty ratio trim is three bits, reset value 000.
// RULE15 - Pattern test is enabled by control bit 7 at one; reset leaves it off.
// RULE16 - In pattern test, true outputs show the pattern, complementary outputs its inverse.
// RULE17 - Write starts on first low-enable edge after a high one; fields shift MSB first.
// RULE18 - Transfer happens on the twentieth low-enable edge; later low edges are ignored.
// RULE19 - Enable returning high before transfer abandons the write without any change.
// RULE20 - Port select low restores reset values; timing reset does not touch registers.
// RULE21 - Fields stay as static outputs until rewritten or reset; no read-back.
`timescale 1ns/1ps
`default_nettype none
`include "asc_consts.svh"
module asc_regs (
  // Core clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // Serial port pins
  input wire logic link_clk_i,
  input wire logic port_select_i,
  input wire logic load_en_n_i,
  input wire logic serial_data_i,
  // Timing reset, kept away from the registers
  input wire logic timing_reset_n_i,
  // Conversion data from the converter core
  input wire logic [`ASC_PAT_MSB:0] conv_data_i,
  // Mode outputs
  output logic standby_bit_o,
  output logic th_transparent_o,
  output logic pattern_test_o,
  // Trim outputs
  output logic [`ASC_TRIM8_MSB:0] gain_trim_o,
  output logic [`ASC_TRIM8_MSB:0] offset_trim_o,
  output logic [`ASC_LEVEL_MSB-`ASC_LEVEL_LSB:0] internal_level_trim_o,
  output logic [`ASC_SETTLE_MSB-`ASC_SETTLE_LSB:0] settling_delay_trim_o,
  output logic [`ASC_DUTY_MSB-`ASC_DUTY_LSB:0] duty_ratio_trim_o,
  // Converter outputs
  output logic [`ASC_PAT_MSB:0] out_bits_o,
  output logic [`ASC_PAT_MSB:0] inverted_output_bits_o,
  // Status
  output logic port_active_o,
  output logic write_strobe_o,
  output logic [`ASC_ADDR_W-1:0] write_addr_o
);
  import asc_pkg::*;

  function automatic logic addr_is(input logic [`ASC_ADDR_W-1:0] a,
                                   input logic [`ASC_ADDR_W-1:0] target);
    addr_is = (a == target);
  endfunction : addr_is

  asc_core_state_t st;
  asc_core_state_t next_st;

  logic link_port_on;
  logic link_reset_n;
  logic [`ASC_FRAME_W-1:0] link_word;
  logic link_toggle;
  logic core_port_on;
  logic core_toggle;
  logic [`ASC_ADDR_W-1:0] word_addr;
  logic [`ASC_DATA_W-1:0] word_data;
  logic new_word;
  logic unused_timing_reset;

  // Port select and core reset seen on the serial clock
  asc_sync #(
    .WIDTH(1)
  ) u_link_port_sync (
    .clk_i(link_clk_i),
    .async_i(port_select_i),
    .sync_o(link_port_on)
  );

  asc_sync #(
    .WIDTH(1)
  ) u_link_reset_sync (
    .clk_i(link_clk_i),
    .async_i(reset_n_i),
    .sync_o(link_reset_n)
  );

  asc_link_shift u_link (
    .link_clk_i(link_clk_i),
    .link_reset_n_i(link_reset_n),
    .port_on_i(link_port_on),
    .load_en_n_i(load_en_n_i),
    .serial_data_i(serial_data_i),
    .word_o(link_word),
    .word_toggle_o(link_toggle)
  );

  // Port select and word toggle seen on the core clock
  asc_sync #(
    .WIDTH(2)
  ) u_core_sync (
    .clk_i(core_clk_i),
    .async_i({port_select_i, link_toggle}),
    .sync_o({core_port_on, core_toggle})
  );

  // Word is stable long before its toggle arrives here
  assign word_addr = link_word[`ASC_FRAME_W-1:`ASC_DATA_W];
  assign word_data = link_word[`ASC_DATA_W-1:0];
  assign new_word = core_toggle ^ st.toggle_seen;
  // Timing reset only resynchronises the output clock elsewhere
  assign unused_timing_reset = timing_reset_n_i; // RULE20

  always_comb begin
    next_st = st;
    next_st.toggle_seen = core_toggle;
    next_st.write_strobe = 1'b0;
    next_st.port_active = core_port_on;
    if (!core_port_on) begin
      // Port select low restores every register
      next_st.ctrl = `ASC_RST_CTRL; // RULE20
      next_st.gain = `ASC_RST_GAIN; // RULE8
      next_st.offs = `ASC_RST_OFFS; // RULE10
      next_st.intl = `ASC_RST_INTL; // RULE12 RULE13 RULE14
      next_st.pat = `ASC_RST_PAT;
    end else if (new_word) begin // RULE1
      next_st.write_strobe = 1'b1;
      next_st.write_addr = word_addr;
      if (addr_is(word_addr, `ASC_ADDR_CTRL)) begin // RULE3
        next_st.ctrl = word_data; // RULE4 RULE6 RULE15
      end else if (addr_is(word_addr, `ASC_ADDR_GAIN)) begin
        next_st.gain = word_data; // RULE7
      end else if (addr_is(word_addr, `ASC_ADDR_OFFS)) begin
        next_st.offs = word_data; // RULE9
      end else if (addr_is(word_addr, `ASC_ADDR_INTL)) begin
        next_st.intl = word_data; // RULE11
      end else if (addr_is(word_addr, `ASC_ADDR_PAT)) begin
        next_st.pat = word_data;
      end else begin
        // Spare and unmapped addresses change no register, only the write strobe and address
        next_st.write_addr = word_addr; // RULE3
      end
    end
    // Pattern replaces conversion data while test mode is on
    if (st.ctrl[`ASC_CTRL_PTEST_BIT]) begin // RULE16
      next_st.out_bits = st.pat[`ASC_PAT_MSB:0];
      next_st.inv_bits = ~st.pat[`ASC_PAT_MSB:0];
    end else begin
      next_st.out_bits = conv_data_i;
      next_st.inv_bits = ~conv_data_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      st.ctrl <= `ASC_RST_CTRL;
      st.gain <= `ASC_RST_GAIN;
      st.offs <= `ASC_RST_OFFS;
      st.intl <= `ASC_RST_INTL;
      st.pat <= `ASC_RST_PAT;
      // Follow the toggle so no load is seen at release
      st.toggle_seen <= core_toggle;
      st.write_strobe <= 1'b0;
      st.write_addr <= 3'h0;
      st.port_active <= 1'b0;
      st.out_bits <= 12'h000;
      st.inv_bits <= 12'hfff;
    end else begin
      st <= next_st;
    end
  end

  // Static field outputs, no read-back path
  assign standby_bit_o = st.ctrl[`ASC_CTRL_STANDBY_BIT_BIT]; // RULE4 RULE21
  assign th_transparent_o = st.ctrl[`ASC_CTRL_TH_BIT]; // RULE6
  assign pattern_test_o = st.ctrl[`ASC_CTRL_PTEST_BIT]; // RULE15
  assign gain_trim_o = st.gain[`ASC_TRIM8_MSB:0]; // RULE7
  assign offset_trim_o = st.offs[`ASC_TRIM8_MSB:0]; // RULE9
  assign internal_level_trim_o = st.intl[`ASC_LEVEL_MSB:`ASC_LEVEL_LSB]; // RULE12
  assign settling_delay_trim_o = st.intl[`ASC_SETTLE_MSB:`ASC_SETTLE_LSB]; // RULE13
  assign duty_ratio_trim_o = st.intl[`ASC_DUTY_MSB:`ASC_DUTY_LSB]; // RULE14
  assign out_bits_o = st.out_bits;
  assign inverted_output_bits_o = st.inv_bits;
  assign port_active_o = st.port_active;
  assign write_strobe_o = st.write_strobe;
  assign write_addr_o = st.write_addr;
endmodule : asc_regs
`default_nettype wire

// File: test/asc_regs_sva.sv
// Purpose: Port checker for the register bank
// Assumes: Core clock domain only
// Notes: Bound to asc_regs
`timescale 1ns/1ps
`default_nettype none
`include "asc_consts.svh"
module asc_regs_sva (
  // Clock, reset, pins
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic port_select_i,
  input wire logic [`ASC_PAT_MSB:0] conv_data_i,
  // Observed outputs
  input wire logic standby_bit_o,
  input wire logic th_transparent_o,
  input wire logic pattern_test_o,
  input wire logic [`ASC_TRIM8_MSB:0] gain_trim_o,
  input wire logic [`ASC_TRIM8_MSB:0] offset_trim_o,
  input wire logic [`ASC_LEVEL_MSB-`ASC_LEVEL_LSB:0] internal_level_trim_o,
  input wire logic [`ASC_PAT_MSB:0] out_bits_o,
  input wire logic [`ASC_PAT_MSB:0] inverted_output_bits_o,
  input wire logic port_active_o,
  input wire logic write_strobe_o,
  input wire logic [`ASC_ADDR_W-1:0] write_addr_o
);
  logic [2:0] sel_hi;
  logic steady;
  // Port select seen high for seven cycles
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i || !port_select_i) begin
      sel_hi <= 3'h0;
    end else if (sel_hi != 3'h7) begin
      sel_hi <= sel_hi + 3'h1;
    end
  end
  assign steady = (sel_hi == 3'h7);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  strobe_pulse_a: assert property (write_strobe_o |=> !write_strobe_o)
    else $error("write strobe longer than one cycle");
  gain_write_a: assert property (steady && $changed(gain_trim_o) |->
    write_strobe_o && write_addr_o == 3'h1) else $error("gain changed without write");
  offs_write_a: assert property (steady && $changed(offset_trim_o) |->
    write_strobe_o && write_addr_o == 3'h2) else $error("offset changed without write");
  level_write_a: assert property (steady && $changed(internal_level_trim_o) |->
    write_strobe_o && write_addr_o == 3'h4) else $error("level changed without write");
  ctrl_write_a: assert property (steady &&
    $changed({standby_bit_o, th_transparent_o, pattern_test_o}) |->
    write_strobe_o && write_addr_o == 3'h0) else $error("control changed without write");
  inv_pair_a: assert property (inverted_output_bits_o == ~out_bits_o)
    else $error("complementary outputs not inverse");
  pass_through_a: assert property ($past(reset_n_i) && !pattern_test_o &&
    $past(!pattern_test_o) |-> out_bits_o == $past(conv_data_i))
    else $error("converter data not passed");
  port_reset_a: assert property ($fell(port_select_i) |-> ##[1:5]
    (gain_trim_o == 8'h80 && offset_trim_o == 8'h80 && internal_level_trim_o == 5'h10))
    else $error("port select low did not reset");
  port_on_a: assert property (steady |-> port_active_o)
    else $error("port not active");
  cover property (write_strobe_o && write_addr_o == 3'h3);
  cover property (pattern_test_o && standby_bit_o);
  cover property ($fell(port_select_i));
endmodule : asc_regs_sva
bind asc_regs asc_regs_sva u_sva (.core_clk_i, .reset_n_i, .port_select_i, .conv_data_i,
  .standby_bit_o, .th_transparent_o, .pattern_test_o, .gain_trim_o, .offset_trim_o,
  .internal_level_trim_o, .out_bits_o, .inverted_output_bits_o, .port_active_o,
  .write_strobe_o, .write_addr_o);
`default_nettype wire

// File: test/asc_ctl_model.sv
// Purpose: Serial controller model driving the write port
// Assumes: Clock runs only inside calls
// Notes: Released data line shows the inverse of its last value
`timescale 1ns/1ps
`default_nettype none
module asc_ctl_model (
  // Serial pins
  output logic link_clk_o,
  output logic load_en_n_o,
  output logic serial_data_o
);
  initial begin
    link_clk_o = 1'b0;
    load_en_n_o = 1'b1;
    serial_data_o = 1'b0;
  end
  task automatic cyc(input logic en_n, input logic d);
    load_en_n_o = en_n;
    serial_data_o = d;
    #62.5 link_clk_o = 1'b1;
    #62.5 link_clk_o = 1'b0;
  endtask : cyc
  task automatic idle(input int n);
    repeat (n) cyc(1'b1, ~serial_data_o);
  endtask : idle
  // Short nlow aborts, long nlow adds ignored cycles
  task automatic frame(input logic [2:0] a, input logic [15:0] d, input int nlow);
    logic [18:0] w;
    w = {a, d};
    cyc(1'b1, ~serial_data_o);
    for (int i = 0; i < nlow; i++) begin
      cyc(1'b0, (i < 19) ? w[18-i] : ~serial_data_o);
    end
    cyc(1'b1, ~serial_data_o);
  endtask : frame
endmodule : asc_ctl_model
`default_nettype wire

// File: test/test_asc_regs.sv
// Purpose: Self-checking bench of the register bank
// Assumes: Serial frames from the controller model
// Notes: Expected values kept in e_ variables
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_asc_regs;
  logic core_clk_i, reset_n_i, port_select_i, timing_reset_n_i;
  logic [11:0] conv_data_i, outb, invb;
  logic link_clk, load_en_n, sdata, standby, th, ptest, port_act, strobe;
  logic [7:0] gain, offs, e_gain, e_offs;
  logic [4:0] level;
  logic [1:0] settle;
  logic [2:0] duty, waddr;
  logic [15:0] e_ctrl, e_intl;
  int miscompares, cmp_count, strobes;
  asc_ctl_model u_ctl (.link_clk_o(link_clk), .load_en_n_o(load_en_n), .serial_data_o(sdata));
  asc_regs u_dut (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .link_clk_i(link_clk),
    .port_select_i(port_select_i), .load_en_n_i(load_en_n), .serial_data_i(sdata),
    .timing_reset_n_i(timing_reset_n_i), .conv_data_i(conv_data_i), .standby_bit_o(standby),
    .th_transparent_o(th), .pattern_test_o(ptest), .gain_trim_o(gain), .offset_trim_o(offs),
    .internal_level_trim_o(level), .settling_delay_trim_o(settle), .duty_ratio_trim_o(duty),
    .out_bits_o(outb), .inverted_output_bits_o(invb), .port_active_o(port_act),
    .write_strobe_o(strobe), .write_addr_o(waddr));
  initial begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) if (strobe === 1'b1) strobes++;
  task automatic end_of_test();
    $display("Mismatches %0d, comparisons %0d", miscompares, cmp_count);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test
  task automatic wr(input logic [2:0] a, input logic [15:0] d, input int nlow, input int n);
    int s0;
    s0 = strobes;
    u_ctl.frame(a, d, nlow);
    repeat (6) @(negedge core_clk_i);
    `CHK(strobes - s0, n)
    if (n == 1) `CHK(waddr, a)
  endtask : wr
  task automatic chk();
    `CHK({ptest, th, standby}, {e_ctrl[7], e_ctrl[3], e_ctrl[0]})
    `CHK(gain, e_gain)
    `CHK(offs, e_offs)
    `CHK({duty, settle, level}, {e_intl[15:13], e_intl[6:5], e_intl[4:0]})
  endtask : chk
  initial begin
    logic [15:0] v;
    reset_n_i = 1'b0;
    port_select_i = 1'b1;
    timing_reset_n_i = 1'b1;
    conv_data_i = 12'h000;
    miscompares = 0;
    cmp_count = 0;
    strobes = 0;
    e_ctrl = 16'h0040;
    e_gain = 8'h80;
    e_offs = 8'h80;
    e_intl = 16'h1410;
    fork
      u_ctl.idle(8);
      repeat (12) @(negedge core_clk_i);
    join
    reset_n_i = 1'b1;
    u_ctl.idle(3);
    chk();
    `CHK(port_act, 1'b1)
    @(negedge core_clk_i);
    conv_data_i = 12'h3c5;
    repeat (2) @(negedge core_clk_i);
    `CHK(outb, 12'h3c5)
    wr(3'h1, 16'hff5a, 20, 1);
    e_gain = 8'h5a;
    chk();
    wr(3'h2, 16'h007f, 20, 1);
    e_offs = 8'h7f;
    chk();
    for (int i = 0; i < 4; i++) begin
      v = {3'b010, 6'h00, i[1:0], 5'h1f};
      wr(3'h4, v, 20, 1);
      e_intl = v;
      chk();
    end
    wr(3'h3, 16'hffff, 20, 1);
    chk();
    wr(3'h1, 16'h0011, 10, 0);
    chk();
    wr(3'h2, 16'h0081, 25, 1);
    e_offs = 8'h81;
    chk();
    wr(3'h5, 16'hfaa5, 20, 1);
    wr(3'h0, 16'h0089, 20, 1);
    e_ctrl = 16'h0089;
    chk();
    `CHK(outb, 12'haa5)
    `CHK(invb, 12'h55a)
    wr(3'h0, 16'h0000, 20, 1);
    e_ctrl = 16'h0000;
    timing_reset_n_i = 1'b0;
    repeat (2) @(negedge core_clk_i);
    timing_reset_n_i = 1'b1;
    chk();
    port_select_i = 1'b0;
    repeat (6) @(negedge core_clk_i);
    wr(3'h1, 16'h0033, 20, 0);
    {e_ctrl, e_gain, e_offs, e_intl} = {16'h0040, 8'h80, 8'h80, 16'h1410};
    chk();
    `CHK(port_act, 1'b0)
    port_select_i = 1'b1;
    repeat (6) @(negedge core_clk_i);
    // Serial side needs its own edges to see port select high
    u_ctl.idle(3);
    wr(3'h1, 16'h0044, 20, 1);
    e_gain = 8'h44;
    chk();
    end_of_test();
  end
endmodule : test_asc_regs
`default_nettype wire
